// ### core/prcfg_regs.sv
// Functional notes
// RULE_01: bit 1 skews transmit clock, reset 0
// RULE_02: bit 0 skews receive clock, reset 0
// RULE_03: control bit 2 reserved, reads zero
// RULE_04: second control bit 4 bypasses async fifo
// RULE_05: bit 11 disables 1.5 ms packet abort
// RULE_06: bits 10:7 set unlock recovery milliseconds
// RULE_07: bit 6 forces good 100 Mbps link
// RULE_08: bit 5 enhanced ternary detect, reset 1
// RULE_09: bit 4 enables enhanced gap detection
// RULE_10: bit 3 bypasses receive block decoder
// RULE_11: bit 2 turns scrambler off
// RULE_12: bit 1 flags odd nibble frames
// RULE_13: bit 0 early rx valid; 15:12 zero
// RULE_14: control bit 7 enables mac side, reset 1
// RULE_15: bits 4:3 transmit fifo mid level
// RULE_16: bits 6:5 receive fifo mid level
// RULE_17: skew amounts parameters; fields passed unchanged
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module prcfg_regs
	import prcfg_pkg::*;
#(
	parameter int unsigned        TIMEOUT_CYC   = DSC_TIMEOUT_CYC, // packet limit
	parameter int unsigned        MS_CYC        = MS_UNIT_CYC,     // one ms
	parameter logic [SKEW_W-1:0]  TX_SKEW_STEPS = 4'h8,            // tx shift
	parameter logic [SKEW_W-1:0]  RX_SKEW_STEPS = 4'h8             // rx shift
) (
	// apb clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb request
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [PDATA_W-1:0] pwdata,
	input  wire logic [3:0]         pstrb,
	// apb answer
	output logic                    pready,
	output logic [PDATA_W-1:0]      prdata,
	output logic                    pslverr,
	// rgmii datapath controls
	output prcfg_rgmii_t            rgmii_cfg,
	output logic [SKEW_W-1:0]       tx_skew_amount,
	output logic [SKEW_W-1:0]       rx_skew_amount,
	// 100base-tx pcs controls
	output prcfg_fe_t               fe_cfg,
	// pcs status and receive gating
	input  wire prcfg_pcs_in_t      pcs_in,
	output prcfg_pcs_out_t          pcs_out
);

	// --------------------------------------------------
	// state of the block
	// --------------------------------------------------
	typedef struct packed {
		logic [REG_W-1:0]   rg_ctl;    // mac interface control
		logic [REG_W-1:0]   rg_ctl2;   // async fifo control
		logic [REG_W-1:0]   fe_reg;    // 100base-tx options
		logic               sts_tout;  // sticky: packet timed out
		logic               sts_odd;   // sticky: odd nibble frame
		logic [PDATA_W-1:0] rdata;     // read data, captured in setup
		logic               link_good; // qualified or forced link
		logic               active_d;  // rx_active one cycle late
		logic               locked_d;  // desc_locked one cycle late
		prcfg_dsc_state_t   dsc;       // descrambler supervision
	} prcfg_state_t;

	prcfg_state_t st_ff;    // registered state
	prcfg_state_t nxt_st;   // next state

	// --------------------------------------------------
	// bus decode
	// --------------------------------------------------
	logic [IDX_W-1:0] idx;        // word index of the access
	logic             hit;        // address maps to a register
	logic             wr_acc;     // write in its access phase
	logic             rd_setup;   // read in its setup phase
	logic [REG_W-1:0] lane;       // byte-lane write mask
	logic [REG_W-1:0] rd_word;    // selected register value
	logic [REG_W-1:0] sts_word;   // live status word

	assign idx    = paddr[PADDR_W-1:2];
	assign hit    = (idx == IDX_RGMII_CTL) || (idx == IDX_RGMII_CTL2) ||
	                (idx == IDX_FE_CFG) || (idx == IDX_STATUS);
	// the slave never stretches a transfer
	assign pready = 1'b1;
	// an unmapped word is refused in the access phase
	assign pslverr = psel & penable & ~hit;
	assign wr_acc  = psel & penable & pwrite & hit;
	// read data is captured one cycle ahead so prdata comes from a flop
	assign rd_setup = psel & ~penable & ~pwrite;
	assign lane     = {{BYTE_W{pstrb[1]}}, {BYTE_W{pstrb[0]}}};

	// --------------------------------------------------
	// timers and nibble check
	// --------------------------------------------------
	logic             tout_start;  // arm the packet length timer
	logic             tout_clear;  // drop it outside a packet
	logic             tout_exp;    // packet ran past the limit
	logic             rec_start;   // arm the recovery timer
	logic             rec_busy;    // recovery still running
	logic             frame_end;   // rx_active fell
	logic             unlock;      // desc_locked fell
	logic             odd_pulse;   // frame carried odd nibbles
	logic [TMR_W-1:0] rec_len;     // recovery length in cycles

	// millisecond units scaled to clock cycles
	assign rec_len = TMR_W'(MS_CYC) * TMR_W'(fe_cfg.descrambler_timer_value); // RULE_06

	assign frame_end = st_ff.active_d & ~pcs_in.rx_active;
	assign unlock    = st_ff.locked_d & ~pcs_in.desc_locked;

	// packet length timer
	prcfg_timer #(
		.W        (TMR_W)
	) u_tout (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (tout_start),
		.clear    (tout_clear),
		.load_val (TMR_W'(TIMEOUT_CYC)),
		.busy     (),
		.expired  (tout_exp)
	);

	// unlock recovery timer
	prcfg_timer #(
		.W        (TMR_W)
	) u_rec (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (rec_start),
		.clear    (1'b0),
		.load_val (rec_len),
		.busy     (rec_busy),
		.expired  ()
	);

	// odd nibble counter, reports only while enabled
	prcfg_nibble_parity u_par (
		.pclk         (pclk),
		.presetn      (presetn),
		.enable       (fe_cfg.odd_nibble_check),   // RULE_12
		.nibble_valid (pcs_in.nibble_valid),
		.frame_end    (frame_end),
		.odd_pulse    (odd_pulse)
	);

	// --------------------------------------------------
	// status word as software sees it
	// --------------------------------------------------
	always_comb begin
		sts_word = '0;
		sts_word[ST_TOUT_B] = st_ff.sts_tout;
		sts_word[ST_ODD_B]  = st_ff.sts_odd;
		sts_word[ST_REC_B]  = (st_ff.dsc == DSC_RECOVER);
		sts_word[ST_LINK_B] = st_ff.link_good;
		sts_word[ST_HOLD_B] = pcs_out.rx_hold;
	end

	// --------------------------------------------------
	// read multiplexer
	// --------------------------------------------------
	// reserved bits are never stored, so they read as zero
	always_comb begin
		case (idx)
			IDX_RGMII_CTL: begin
				rd_word = st_ff.rg_ctl;    // RULE_03
			end
			IDX_RGMII_CTL2: begin
				rd_word = st_ff.rg_ctl2;
			end
			IDX_FE_CFG: begin
				rd_word = st_ff.fe_reg;
			end
			IDX_STATUS: begin
				rd_word = sts_word;
			end
			default: begin
				rd_word = '0;              // unmapped reads zero
			end
		endcase
	end

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		nxt_st     = st_ff;
		tout_start = 1'b0;
		rec_start  = 1'b0;

		// delayed copies for edge detection
		nxt_st.active_d = pcs_in.rx_active;
		nxt_st.locked_d = pcs_in.desc_locked;

		// forcing overrides qualification, never the reverse
		nxt_st.link_good = pcs_in.link_qualified | fe_cfg.force_link_good; // RULE_07

		// read data captured in setup, held through access
		if (rd_setup) begin
			nxt_st.rdata = PDATA_W'(rd_word);
		end

		// configuration writes honour byte lanes and writable bits
		if (wr_acc && idx == IDX_RGMII_CTL) begin
			nxt_st.rg_ctl = (st_ff.rg_ctl & ~(RGMII_CTL_WMASK & lane)) |
			                (pwdata[REG_W-1:0] & RGMII_CTL_WMASK & lane); // RULE_03
		end
		if (wr_acc && idx == IDX_RGMII_CTL2) begin
			nxt_st.rg_ctl2 = (st_ff.rg_ctl2 & ~(RGMII_CTL2_WMSK & lane)) |
			                 (pwdata[REG_W-1:0] & RGMII_CTL2_WMSK & lane); // RULE_04
		end
		if (wr_acc && idx == IDX_FE_CFG) begin
			nxt_st.fe_reg = (st_ff.fe_reg & ~(FE_CFG_WMASK & lane)) |
			                (pwdata[REG_W-1:0] & FE_CFG_WMASK & lane); // RULE_13
		end

		// sticky flags: write one to clear, a new event wins
		if (wr_acc && idx == IDX_STATUS && lane[ST_TOUT_B] && pwdata[ST_TOUT_B]) begin
			nxt_st.sts_tout = 1'b0;
		end
		if (wr_acc && idx == IDX_STATUS && lane[ST_ODD_B] && pwdata[ST_ODD_B]) begin
			nxt_st.sts_odd = 1'b0;
		end
		if (odd_pulse) begin
			nxt_st.sts_odd = 1'b1;         // RULE_12
		end

		// descrambler supervision
		case (st_ff.dsc)
			DSC_IDLE: begin
				// a lost lock always costs a recovery period
				if (unlock) begin
					rec_start  = 1'b1;
					nxt_st.dsc = DSC_RECOVER;
				end else if (pcs_in.rx_active && !st_ff.active_d &&
				             !fe_cfg.descrambler_timer_disable) begin
					tout_start = 1'b1;     // RULE_05
					nxt_st.dsc = DSC_TIMING;
				end
			end
			DSC_TIMING: begin
				if (unlock) begin
					rec_start  = 1'b1;
					nxt_st.dsc = DSC_RECOVER;
				end else if (!pcs_in.rx_active || fe_cfg.descrambler_timer_disable) begin
					nxt_st.dsc = DSC_IDLE; // packet ended in time, or check off
				end else if (tout_exp) begin
					nxt_st.sts_tout = 1'b1;
					nxt_st.dsc      = DSC_ABORT; // RULE_05
				end
			end
			DSC_ABORT: begin
				// reception stays cut until the long packet has gone
				if (!pcs_in.rx_active) begin
					rec_start  = 1'b1;     // RULE_06
					nxt_st.dsc = DSC_RECOVER;
				end
			end
			DSC_RECOVER: begin
				// a zero setting gives a one-cycle pass through here
				if (!rec_busy) begin
					nxt_st.dsc = DSC_IDLE; // RULE_06
				end
			end
			default: begin
				nxt_st.dsc = DSC_IDLE;
			end
		endcase
	end

	// packet length timer is only live while timing a packet
	assign tout_clear = (st_ff.dsc != DSC_TIMING);

	// --------------------------------------------------
	// register the state
	// --------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff.rg_ctl    <= RGMII_CTL_RST;  // RULE_14
			st_ff.rg_ctl2   <= RGMII_CTL2_RST;
			st_ff.fe_reg    <= FE_CFG_RST;     // RULE_08
			st_ff.sts_tout  <= 1'b0;
			st_ff.sts_odd   <= 1'b0;
			st_ff.rdata     <= '0;
			st_ff.link_good <= 1'b0;
			st_ff.active_d  <= 1'b0;
			st_ff.locked_d  <= 1'b0;
			st_ff.dsc       <= DSC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// --------------------------------------------------
	// outputs to the rgmii datapath
	// --------------------------------------------------
	// fields go out exactly as stored; their meaning lives downstream
	assign rgmii_cfg.rgmii_enable      = st_ff.rg_ctl[RG_EN_B];                // RULE_14
	assign rgmii_cfg.rx_fifo_mid_level = st_ff.rg_ctl[RG_RX_MID_LSB +: MID_W]; // RULE_16
	assign rgmii_cfg.tx_fifo_mid_level = st_ff.rg_ctl[RG_TX_MID_LSB +: MID_W]; // RULE_15
	assign rgmii_cfg.tx_clock_skew     = st_ff.rg_ctl[RG_TX_SKEW_B];           // RULE_01
	assign rgmii_cfg.rx_clock_skew     = st_ff.rg_ctl[RG_RX_SKEW_B];           // RULE_02
	assign rgmii_cfg.async_fifo_bypass = st_ff.rg_ctl2[RG2_BYPASS_B];          // RULE_04

	// shift amount is fixed at build time; software only picks on or off
	assign tx_skew_amount = st_ff.rg_ctl[RG_TX_SKEW_B] ? TX_SKEW_STEPS : '0;  // RULE_17
	assign rx_skew_amount = st_ff.rg_ctl[RG_RX_SKEW_B] ? RX_SKEW_STEPS : '0;  // RULE_17

	// --------------------------------------------------
	// outputs to the 100base-tx pcs
	// --------------------------------------------------
	assign fe_cfg.descrambler_timer_disable = st_ff.fe_reg[FE_TDIS_B];             // RULE_05
	assign fe_cfg.descrambler_timer_value   = st_ff.fe_reg[FE_TVAL_LSB +: TVAL_W]; // RULE_06
	assign fe_cfg.force_link_good           = st_ff.fe_reg[FE_FORCE_B];            // RULE_07
	assign fe_cfg.enhanced_ternary_detect   = st_ff.fe_reg[FE_TERN_B];             // RULE_08
	assign fe_cfg.enhanced_gap_detect       = st_ff.fe_reg[FE_GAP_B];              // RULE_09
	assign fe_cfg.rx_block_decoder_bypass   = st_ff.fe_reg[FE_DEC_B];              // RULE_10
	assign fe_cfg.scrambler_off             = st_ff.fe_reg[FE_SCR_B];              // RULE_11
	assign fe_cfg.odd_nibble_check          = st_ff.fe_reg[FE_ODD_B];              // RULE_12
	assign fe_cfg.early_rx_valid            = st_ff.fe_reg[FE_EARLY_B];            // RULE_13

	// --------------------------------------------------
	// receive gating and link back to the pcs
	// --------------------------------------------------
	// abort cuts the current packet; hold blocks new ones while recovering
	assign pcs_out.rx_abort   = (st_ff.dsc == DSC_ABORT);   // RULE_05
	assign pcs_out.rx_hold    = (st_ff.dsc == DSC_RECOVER); // RULE_06
	assign pcs_out.link_good  = st_ff.link_good;            // RULE_07
	assign pcs_out.odd_nibble = odd_pulse;                  // RULE_12

	// bus read data
	assign prdata = st_ff.rdata;

endmodule : prcfg_regs

`default_nettype wire

// ### core/prcfg_pkg.sv
package prcfg_pkg;

	// --------------------------------------------------
	// bus geometry
	// --------------------------------------------------
	localparam int unsigned PADDR_W = 12;               // apb byte address width
	localparam int unsigned PDATA_W = 32;               // apb data width
	localparam int unsigned IDX_W   = PADDR_W - 2;      // word index width
	localparam int unsigned REG_W   = 16;               // stored register width
	localparam int unsigned BYTE_W  = 8;                // one strobe lane

	// --------------------------------------------------
	// register indices: byte address is four times the index
	// --------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_RGMII_CTL  = 10'h032;
	localparam logic [IDX_W-1:0] IDX_RGMII_CTL2 = 10'h033;
	localparam logic [IDX_W-1:0] IDX_FE_CFG     = 10'h034;
	localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h035;

	// --------------------------------------------------
	// reset values and masks
	// --------------------------------------------------
	localparam logic [REG_W-1:0] RGMII_CTL_RST   = 16'h00D0;
	localparam logic [REG_W-1:0] RGMII_CTL_WMASK = 16'h00FB;
	localparam logic [REG_W-1:0] RGMII_CTL2_RST  = 16'h0000;
	localparam logic [REG_W-1:0] RGMII_CTL2_WMSK = 16'h0010;
	localparam logic [REG_W-1:0] FE_CFG_RST      = 16'h07A0;
	localparam logic [REG_W-1:0] FE_CFG_WMASK    = 16'h0FFF;

	// --------------------------------------------------
	// field positions
	// --------------------------------------------------
	localparam int unsigned RG_RX_SKEW_B  = 0;
	localparam int unsigned RG_TX_SKEW_B  = 1;
	localparam int unsigned RG_TX_MID_LSB = 3;
	localparam int unsigned RG_RX_MID_LSB = 5;
	localparam int unsigned MID_W         = 2;
	localparam int unsigned RG_EN_B       = 7;
	localparam int unsigned RG2_BYPASS_B  = 4;
	localparam int unsigned FE_EARLY_B    = 0;
	localparam int unsigned FE_ODD_B      = 1;
	localparam int unsigned FE_SCR_B      = 2;
	localparam int unsigned FE_DEC_B      = 3;
	localparam int unsigned FE_GAP_B      = 4;
	localparam int unsigned FE_TERN_B     = 5;
	localparam int unsigned FE_FORCE_B    = 6;
	localparam int unsigned FE_TVAL_LSB   = 7;
	localparam int unsigned TVAL_W        = 4;
	localparam int unsigned FE_TDIS_B     = 11;
	localparam int unsigned ST_TOUT_B     = 0;
	localparam int unsigned ST_ODD_B      = 1;
	localparam int unsigned ST_REC_B      = 2;
	localparam int unsigned ST_LINK_B     = 3;
	localparam int unsigned ST_HOLD_B     = 4;

	// --------------------------------------------------
	// timing
	// --------------------------------------------------
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned DSC_TIMEOUT_US  = 1500;
	localparam int unsigned DSC_TIMEOUT_CYC = DSC_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned MS_UNIT_US      = 1000;
	localparam int unsigned MS_UNIT_CYC     = MS_UNIT_US * CLK_MHZ;
	localparam int unsigned TMR_W           = 24;
	localparam int unsigned SKEW_W          = 4;

	// --------------------------------------------------
	// carriers
	// --------------------------------------------------
	typedef struct packed {
		logic              rgmii_enable;
		logic [MID_W-1:0]  rx_fifo_mid_level;
		logic [MID_W-1:0]  tx_fifo_mid_level;
		logic              tx_clock_skew;
		logic              rx_clock_skew;
		logic              async_fifo_bypass;
	} prcfg_rgmii_t;

	typedef struct packed {
		logic              descrambler_timer_disable;
		logic [TVAL_W-1:0] descrambler_timer_value;
		logic              force_link_good;
		logic              enhanced_ternary_detect;
		logic              enhanced_gap_detect;
		logic              rx_block_decoder_bypass;
		logic              scrambler_off;
		logic              odd_nibble_check;
		logic              early_rx_valid;
	} prcfg_fe_t;

	typedef struct packed {
		logic rx_active;
		logic desc_locked;
		logic link_qualified;
		logic nibble_valid;
	} prcfg_pcs_in_t;

	typedef struct packed {
		logic rx_abort;
		logic rx_hold;
		logic link_good;
		logic odd_nibble;
	} prcfg_pcs_out_t;

	typedef enum logic [1:0] {
		DSC_IDLE    = 2'b00,
		DSC_TIMING  = 2'b01,
		DSC_ABORT   = 2'b10,
		DSC_RECOVER = 2'b11
	} prcfg_dsc_state_t;

endpackage : prcfg_pkg

// ### core/prcfg_timer.sv
`timescale 1ns/1ps
`default_nettype none

module prcfg_timer
	import prcfg_pkg::*;
#(
	parameter int unsigned W = TMR_W   // counter width
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] load_val,
	// status
	output logic              busy,
	output logic              expired
);

	// --------------------------------------------------
	// state
	// --------------------------------------------------
	typedef struct packed {
		logic [W-1:0] count;   // cycles left
		logic         expired; // one-cycle end pulse
	} prcfg_tmr_t;

	prcfg_tmr_t tmr_ff;      // registered state
	prcfg_tmr_t nxt_tmr;     // next state

	// start wins over clear so a restart is never lost
	always_comb begin
		nxt_tmr = tmr_ff;
		nxt_tmr.expired = 1'b0;
		if (start) begin
			nxt_tmr.count = load_val;
		end else if (clear) begin
			nxt_tmr.count = '0;
		end else if (tmr_ff.count != '0) begin
			nxt_tmr.count   = tmr_ff.count - W'(1);
			nxt_tmr.expired = (tmr_ff.count == W'(1));
		end
	end

	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_ff <= '0;
		end else begin
			tmr_ff <= nxt_tmr;
		end
	end

	assign busy    = (tmr_ff.count != '0);
	assign expired = tmr_ff.expired;

endmodule : prcfg_timer

`default_nettype wire

// ### core/prcfg_nibble_parity.sv
`timescale 1ns/1ps
`default_nettype none

module prcfg_nibble_parity
	import prcfg_pkg::*;
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// receive stream
	input  wire logic enable,
	input  wire logic nibble_valid,
	input  wire logic frame_end,
	// result
	output logic      odd_pulse
);

	// --------------------------------------------------
	// state
	// --------------------------------------------------
	typedef struct packed {
		logic parity;  // running nibble count, low bit
		logic odd;     // one-cycle odd-frame pulse
	} prcfg_par_t;

	prcfg_par_t par_ff;   // registered state
	prcfg_par_t nxt_par;  // next state

	// frame end reports and restarts the count
	always_comb begin
		nxt_par = par_ff;
		nxt_par.odd = 1'b0;
		if (frame_end) begin
			nxt_par.odd    = enable & par_ff.parity;
			nxt_par.parity = 1'b0;
		end else if (nibble_valid) begin
			nxt_par.parity = ~par_ff.parity;
		end
	end

	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_ff <= '0;
		end else begin
			par_ff <= nxt_par;
		end
	end

	assign odd_pulse = par_ff.odd;

endmodule : prcfg_nibble_parity

`default_nettype wire

// ### test/prcfg_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module prcfg_regs_chk
	import prcfg_pkg::*;
(
	// apb side
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [PDATA_W-1:0] pwdata,
	input wire logic [3:0]         pstrb,
	input wire logic [PDATA_W-1:0] prdata,
	// datapath side
	input wire prcfg_rgmii_t       rgmii_cfg,
	input wire logic [SKEW_W-1:0]  tx_skew_amount,
	input wire logic [SKEW_W-1:0]  rx_skew_amount,
	input wire prcfg_fe_t          fe_cfg,
	input wire prcfg_pcs_in_t      pcs_in,
	input wire prcfg_pcs_out_t     pcs_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// full-word write or a read, in its access phase
	sequence s_wr(logic [IDX_W-1:0] ix); psel && penable && pwrite && paddr[11:2] == ix && pstrb == 4'hf; endsequence
	sequence s_rd(logic [IDX_W-1:0] ix); psel && penable && !pwrite && paddr[11:2] == ix; endsequence
	property p_tx_skew; (tx_skew_amount != 4'h0) == rgmii_cfg.tx_clock_skew; endproperty
	a_tx_skew: assert property (p_tx_skew) else $error("tx skew wrong");
	property p_rx_skew; (rx_skew_amount != 4'h0) == rgmii_cfg.rx_clock_skew; endproperty
	a_rx_skew: assert property (p_rx_skew) else $error("rx skew wrong");
	property p_ctl_rd; s_rd(IDX_RGMII_CTL) |-> prdata[2] == 1'b0 && prdata[31:16] == 16'h0000; endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("reserved bits read");
	property p_bypass; s_wr(IDX_RGMII_CTL2) |=> rgmii_cfg.async_fifo_bypass == $past(pwdata[4]); endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not stored");
	property p_fe_wr; s_wr(IDX_FE_CFG) |=> fe_cfg == $past(pwdata[11:0]); endproperty
	a_fe_wr: assert property (p_fe_wr) else $error("fe config not stored");
	property p_fe_rd; s_rd(IDX_FE_CFG) |-> prdata[15:12] == 4'h0; endproperty
	a_fe_rd: assert property (p_fe_rd) else $error("fe reserved read");
	property p_ctl_wr; s_wr(IDX_RGMII_CTL) |=> rgmii_cfg[7:1] == {$past(pwdata[7:3]), $past(pwdata[1:0])}; endproperty
	a_ctl_wr: assert property (p_ctl_wr) else $error("control not stored");
	property p_link; 1 |=> pcs_out.link_good == $past(pcs_in.link_qualified | fe_cfg.force_link_good); endproperty
	a_link: assert property (p_link) else $error("link good wrong");
endmodule : prcfg_regs_chk
bind prcfg_regs prcfg_regs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .rgmii_cfg, .tx_skew_amount, .rx_skew_amount, .fe_cfg, .pcs_in, .pcs_out);
`default_nettype wire

// ### test/prcfg_pcs_model.sv
`timescale 1ns/1ps
`default_nettype none
module prcfg_pcs_model
	import prcfg_pkg::*;
(
	// clock
	input  wire logic         pclk,
	// receive status toward the block
	output var prcfg_pcs_in_t pcs_in
);
	// descrambler locked, link unqualified, line idle
	initial pcs_in = 4'h4;
	// one frame of len cycles, nibbles in its first nib cycles; a low cycle follows
	task automatic frame(input int len, input int nib);
		for (int i = 0; i < len; i++) begin
			@(posedge pclk);
			pcs_in.rx_active    <= 1'b1;
			pcs_in.nibble_valid <= (i < nib);
		end
		@(posedge pclk);
		pcs_in.rx_active    <= 1'b0;
		pcs_in.nibble_valid <= 1'b0;
		@(posedge pclk);
	endtask : frame
	// descrambler drops its lock for one cycle while the line is idle
	task automatic unlock();
		@(posedge pclk);
		pcs_in.desc_locked <= 1'b0;
		@(posedge pclk);
		pcs_in.desc_locked <= 1'b1;
		@(posedge pclk);
	endtask : unlock
endmodule : prcfg_pcs_model
`default_nettype wire

// ### test/prcfg_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module prcfg_regs_bench
	import prcfg_pkg::*;
;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [PADDR_W-1:0] paddr;
	logic [PDATA_W-1:0] pwdata, prdata, rdat;
	logic [3:0]         pstrb;
	prcfg_rgmii_t       rgmii_cfg;
	logic [SKEW_W-1:0]  tx_skew_amount, rx_skew_amount;
	prcfg_fe_t          fe_cfg;
	prcfg_pcs_in_t      pcs_in;
	prcfg_pcs_out_t     pcs_out;
	int                 n_mismatch, cmp_count, cyc, n_ab, n_hd, n_odd;
	// short counts keep the run brief
	prcfg_regs #(.TIMEOUT_CYC(20), .MS_CYC(10)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .rgmii_cfg, .tx_skew_amount, .rx_skew_amount, .fe_cfg, .pcs_in, .pcs_out);
	prcfg_pcs_model pcs_u (.pclk, .pcs_in);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// cycle ceiling and pcs event counters
	always @(posedge pclk) begin
		cyc++;
		n_ab += int'(pcs_out.rx_abort);
		n_hd += int'(pcs_out.rx_hold);
		n_odd += int'(pcs_out.odd_nibble);
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// one apb transfer; waits for pready
	task automatic apb(input logic w, input logic [IDX_W-1:0] ix, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench ceiling ends a wait that never gets its answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [IDX_W-1:0] ix, input logic [31:0] d);
		apb(1'b1, ix, d, 4'hf);
	endtask : wr
	task automatic rd(input logic [IDX_W-1:0] ix, input logic [31:0] exp);
		apb(1'b0, ix, 32'h0000_0000, 4'hf);
		cmp(rdat, exp);
	endtask : rd
	task automatic t_reset();
		rd(IDX_RGMII_CTL, 32'h0000_00d0);
		rd(IDX_RGMII_CTL2, 32'h0000_0000);
		rd(IDX_FE_CFG, 32'h0000_07a0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_rgmii();
		wr(IDX_RGMII_CTL, 32'hffff_ffff);
		rd(IDX_RGMII_CTL, 32'h0000_00fb);
		cmp({24'h0, tx_skew_amount, rx_skew_amount}, 32'h0000_0088);
		wr(IDX_RGMII_CTL, 32'h0000_0000);
		rd(IDX_RGMII_CTL, 32'h0000_0000);
		cmp({24'h0, tx_skew_amount, rx_skew_amount}, 32'h0000_0000);
		wr(IDX_RGMII_CTL2, 32'hffff_ffff);
		rd(IDX_RGMII_CTL2, 32'h0000_0010);
		cmp({24'h0, rgmii_cfg}, 32'h0000_0001);
		$display("rgmii test done");
	endtask : t_rgmii
	task automatic t_fe();
		wr(IDX_FE_CFG, 32'hffff_ffff);
		rd(IDX_FE_CFG, 32'h0000_0fff);
		for (int b = 0; b < 12; b++) begin
			wr(IDX_FE_CFG, 32'h0000_0001 << b);
			rd(IDX_FE_CFG, 32'h0000_0001 << b);
			cmp({20'h0, fe_cfg}, 32'h0000_0001 << b);
		end
		// low lane only: upper byte keeps its value
		apb(1'b1, IDX_FE_CFG, 32'h0000_00ff, 4'h1);
		rd(IDX_FE_CFG, 32'h0000_08ff);
		apb(1'b1, 10'h3ff, 32'hffff_ffff, 4'hf);
		cmp(err, 1);
		rd(10'h3ff, 32'h0000_0000);
		$display("fe test done");
	endtask : t_fe
	task automatic t_pcs();
		wr(IDX_FE_CFG, 32'h0000_00c2);
		repeat (2) @(posedge pclk);
		#1 cmp(pcs_out.link_good, 1);
		{n_ab, n_hd} = '0;
		pcs_u.frame(30, 3);
		repeat (20) @(posedge pclk);
		cmp(n_ab > 0, 1);
		cmp(n_hd inside {[10:12]}, 1);
		n_odd = 0;
		pcs_u.frame(6, 3);
		repeat (2) @(posedge pclk);
		cmp(n_odd, 1);
		apb(1'b0, IDX_STATUS, 32'h0000_0000, 4'hf);
		cmp(rdat[1:0], 2'b11);
		// write one clears both sticky flags; link stays forced up
		wr(IDX_STATUS, 32'h0000_0003);
		rd(IDX_STATUS, 32'h0000_0008);
		wr(IDX_FE_CFG, 32'h0000_0880);
		n_ab = 0;
		pcs_u.frame(30, 4);
		cmp(n_ab, 0);
		// a lost descrambler lock costs one recovery period of one ms
		n_hd = 0;
		pcs_u.unlock();
		repeat (15) @(posedge pclk);
		cmp(n_hd inside {[10:12]}, 1);
		$display("pcs test done");
	endtask : t_pcs
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{n_mismatch, cmp_count, cyc} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rgmii();
		t_fe();
		t_pcs();
		results();
	end
endmodule : prcfg_regs_bench
`default_nettype wire
